// ==== inc/mrb_pkg.sv ====
// Purpose: shared constants, types and decode functions for the base mode register link
// Assumes: one command clock at 100 MHz, one data beat per clock edge
// Notes: device and controller both import this package whole
package mrb_pkg;
	typedef enum logic [1:0] {MRB_NOP, MRB_MRS, MRB_RD, MRB_WR} mrb_cmd_t;

	localparam int MR_W = 18;
	localparam int COL_W = 6;
	localparam int COLS = 64;
	localparam int DQ_W = 8;
	localparam int BEATS = 8;
	localparam int BL_LO = 0;
	localparam int BT_BIT = 3;
	localparam int CL_EXT_BIT = 2;
	localparam int CL_LO = 4;
	localparam int DLL_RST_BIT = 8;
	localparam int WR_LO = 9;
	localparam int PPD_BIT = 12;
	localparam int OTF_BIT = 12;
	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_OTF = 2'h1;
	localparam logic [1:0] BL_CHOP = 2'h2;
	localparam logic [MR_W-1:0] MR_RESERVED = 18'h2_6080;
	localparam logic [MR_W-1:0] MR_RESET = 18'h0_0000;
	localparam logic [2:0] BASE_BANK = 3'h0;
	localparam logic [2:0] LAST_BEAT = 3'h7;

	localparam logic [9:0] DLL_LOCK_CYC = 10'h200;
	localparam logic [3:0] MOD_CYC = 4'hc;
	localparam logic [3:0] XP_CYC = 4'h3;
	localparam logic [3:0] XPDLL_CYC = 4'ha;
	localparam int CLK_PERIOD_NS = 10;
	localparam int WR_TIME_NS = 15;
	localparam int WR_MIN_CYC = 5;
	localparam int WR_RAW_CYC = (WR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_CYC = (WR_RAW_CYC < WR_MIN_CYC) ? WR_MIN_CYC : WR_RAW_CYC;

	localparam logic [7:0] REG_MODE = 8'h00;
	localparam logic [7:0] REG_ACCESS = 8'h04;
	localparam logic [7:0] REG_WDATA_LO = 8'h08;
	localparam logic [7:0] REG_WDATA_HI = 8'h0c;
	localparam logic [7:0] REG_RDATA_LO = 8'h10;
	localparam logic [7:0] REG_RDATA_HI = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;
	localparam logic [7:0] REG_POWER = 8'h1c;
	localparam int ACC_WR_BIT = 24;
	localparam int PWR_DOWN_BIT = 0;

	function automatic logic [3:0] cl_cycles(input logic [MR_W-1:0] m);
		logic [3:0] f;
		f = {1'b0, m[CL_LO+2:CL_LO]};
		if (m[CL_EXT_BIT])
			return 4'hc + f;
		else if (f == 4'h0)
			return 4'h5;
		return 4'h4 + f;
	endfunction

	function automatic logic [3:0] wr_cycles(input logic [2:0] c);
		case (c)
			3'h1: return 4'h5;
			3'h2: return 4'h6;
			3'h3: return 4'h7;
			3'h4: return 4'h8;
			3'h5: return 4'ha;
			3'h6: return 4'hc;
			3'h7: return 4'he;
			default: return 4'h5;
		endcase
	endfunction

	function automatic logic [2:0] wr_code(input int cyc);
		return (cyc <= 8) ? 3'(cyc - 4) : 3'(cyc / 2);
	endfunction

	function automatic logic is_chop(input logic [MR_W-1:0] m, input logic a12);
		return (m[BL_LO+1:BL_LO] == BL_CHOP) || (m[BL_LO+1:BL_LO] == BL_OTF && !a12);
	endfunction

	function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] s,
		input logic [2:0] p, input logic inter, input logic wr, input logic chop);
		if (wr && chop)
			return {s[COL_W-1:2], p[1:0]};
		else if (wr)
			return {s[COL_W-1:3], p};
		else if (inter)
			return {s[COL_W-1:3], s[2:0] ^ p};
		return {s[COL_W-1:3], s[2] ^ p[2], 2'(s[1:0] + p[1:0])};
	endfunction
endpackage

// ==== inc/mrb_link_if.sv ====
// Purpose: command and data link between memory controller and memory device
// Assumes: both ends clocked by the same core clock
// Notes: shared data lane level is resolved here from the device enable alone
`timescale 1ns/1ns
interface mrb_link_if;
	import mrb_pkg::*;
	logic cke;
	mrb_cmd_t cmd;
	logic [2:0] ba;
	logic [MR_W-1:0] addr;
	logic [DQ_W-1:0] ctl_dq;
	logic ctl_dq_oe;
	logic [DQ_W-1:0] dev_dq;
	logic dev_dq_oe;
	logic dev_dqs;
	logic dev_dqs_oe;
	logic [DQ_W-1:0] dq;

	// Undriven lane shows the controller's last value instead of a float
	assign dq = dev_dq_oe ? dev_dq : ctl_dq;

	modport dev (input cke, cmd, ba, addr, dq,
		output dev_dq, dev_dq_oe, dev_dqs, dev_dqs_oe);
	modport ctl (output cke, cmd, ba, addr, ctl_dq, ctl_dq_oe,
		input dq, dev_dqs, dev_dqs_oe);
endinterface

// ==== design/mrb_device.sv ====
// Purpose: memory device end, base mode register decode and burst engine
// Assumes: controller keeps its timing obligations; one beat per clock edge
// Notes: link clock enable freezes all state; commands arriving while busy are dropped
// Function
// - Burst length from mode bits 1:0
// - Per-command mode: address bit 12 picks length
// - Burst wraps inside aligned column block
// - Same burst length for reads and writes
// - Mode bit 3 picks sequential or interleaved
// - Sequential reads add position modulo four
// - Interleaved reads XOR position with start
// - Chop reads float lanes last four beats
// - Writes aligned, low column bits ignored
// - Chop writes four ascending columns, rest ignored
// - Chop bursts start like length-eight bursts
// - DLL reset bit starts reset, self-clears
// - Controller waits 512 cycles before reads
// - Write recovery cycles from mode bits 11:9
// - Controller rounds recovery time up to cycles
// - Bit 12 low stops DLL in power-down
// - Bit 12 high keeps DLL in power-down
// - Read latency from mode bits 6:4 and bit 2
// - First read data at edge n plus m
// - Controller writes reserved mode bits as zero
// - Mode set only when idle, no burst
// - Controller waits mode update delay after set
`timescale 1ns/1ns
module mrb_device
	import mrb_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic resetn_i,
	mrb_link_if.dev link,
	output logic dll_locked_o,
	output logic dll_running_o,
	output logic [3:0] read_latency_o,
	output logic [3:0] write_recovery_o,
	output logic recovery_busy_o,
	output logic burst_busy_o
);
	typedef enum logic [1:0] {D_IDLE, D_RLAT, D_RBEAT, D_WBEAT} mrb_dev_st_t;

	typedef struct packed {
		mrb_dev_st_t st;
		logic [MR_W-1:0] mode;
		logic [COLS-1:0][DQ_W-1:0] mem;
		logic [COL_W-1:0] start;
		logic chop;
		logic [2:0] pos;
		logic [3:0] lat;
		logic [9:0] dll_cnt;
		logic [3:0] rec_cnt;
		logic [DQ_W-1:0] dq;
		logic dq_oe;
		logic dqs;
		logic dqs_oe;
	} mrb_dev_state_t;

	mrb_dev_state_t r;
	mrb_dev_state_t next_r;
	logic [COL_W-1:0] col;
	logic beat_live;

	// Column of the current beat for the burst in flight
	assign col = burst_col(r.start, r.pos, r.mode[BT_BIT], r.st == D_WBEAT, r.chop);

	// Upper half of an eight-beat slot carries nothing in chop mode
	assign beat_live = !(r.chop && r.pos[2]);

	always_comb
	begin
		next_r = r;
		next_r.dq_oe = 1'b0;
		next_r.dqs = 1'b0;
		next_r.dqs_oe = 1'b0;
		next_r.mode[DLL_RST_BIT] = 1'b0;
		if (r.dll_cnt != 10'h000)
		begin
			next_r.dll_cnt = r.dll_cnt - 10'h001;
		end
		if (r.rec_cnt != 4'h0)
		begin
			next_r.rec_cnt = r.rec_cnt - 4'h1;
		end
		case (r.st)
			D_IDLE:
			begin
				if (link.cmd == MRB_MRS && link.ba == BASE_BANK)
				begin
					// Reserved bits are dropped so they never steer anything
					next_r.mode = link.addr & ~MR_RESERVED;
					if (link.addr[DLL_RST_BIT])
					begin
						next_r.dll_cnt = DLL_LOCK_CYC;
					end
				end
				else if (link.cmd == MRB_RD || link.cmd == MRB_WR)
				begin
					next_r.start = link.addr[COL_W-1:0];
					next_r.chop = is_chop(r.mode, link.addr[OTF_BIT]);
					next_r.pos = 3'h0;
					// Latency loaded one short: the beat register adds the last edge
					next_r.lat = cl_cycles(r.mode) - 4'h1;
					if (link.cmd == MRB_RD)
					begin
						next_r.st = D_RLAT;
					end
					else
					begin
						next_r.st = D_WBEAT;
					end
				end
			end
			D_RLAT:
			begin
				// Same wait and slot for chop and full bursts
				next_r.lat = r.lat - 4'h1;
				if (r.lat == 4'h1)
				begin
					next_r.st = D_RBEAT;
				end
			end
			D_RBEAT:
			begin
				next_r.dq = r.mem[col];
				next_r.dq_oe = beat_live;
				next_r.dqs = beat_live;
				next_r.dqs_oe = beat_live;
				next_r.pos = r.pos + 3'h1;
				if (r.pos == LAST_BEAT)
				begin
					next_r.st = D_IDLE;
				end
			end
			D_WBEAT:
			begin
				if (beat_live)
				begin
					next_r.mem[col] = link.dq;
				end
				next_r.pos = r.pos + 3'h1;
				if (r.pos == LAST_BEAT)
				begin
					next_r.st = D_IDLE;
					next_r.rec_cnt = wr_cycles(r.mode[WR_LO+2:WR_LO]);
				end
			end
			default:
			begin
				next_r.st = D_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			r <= '0;
			r.mode <= MR_RESET;
		end
		else if (link.cke)
		begin
			r <= next_r;
		end
	end

	assign link.dev_dq = r.dq;
	assign link.dev_dq_oe = r.dq_oe;
	assign link.dev_dqs = r.dqs;
	assign link.dev_dqs_oe = r.dqs_oe;
	assign dll_locked_o = (r.dll_cnt == 10'h000);
	// DLL stops only when powered down with the slow-exit setting
	assign dll_running_o = link.cke | r.mode[PPD_BIT];
	assign read_latency_o = cl_cycles(r.mode);
	assign write_recovery_o = wr_cycles(r.mode[WR_LO+2:WR_LO]);
	assign recovery_busy_o = (r.rec_cnt != 4'h0);
	assign burst_busy_o = (r.st != D_IDLE);
endmodule // mrb_device

// ==== design/mrb_controller.sv ====
// Purpose: memory controller end, APB register front for mode set, read and write
// Assumes: APB master holds a request until pready; single device on the link
// Notes: issue writes stall on pready until the link can take the command
`timescale 1ns/1ns
module mrb_controller
	import mrb_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic clk_en_i,
	input wire logic [7:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	mrb_link_if.ctl link
);
	typedef enum logic [2:0] {C_IDLE, C_MOD, C_RWAIT, C_WBEAT, C_PD, C_EXIT} mrb_ctl_st_t;

	typedef struct packed {
		mrb_ctl_st_t st;
		logic [MR_W-1:0] mode;
		mrb_cmd_t cmd;
		logic [2:0] ba;
		logic [MR_W-1:0] addr;
		logic [DQ_W-1:0] dq;
		logic dq_oe;
		logic cke;
		logic [BEATS-1:0][DQ_W-1:0] wbuf;
		logic [BEATS-1:0][DQ_W-1:0] rbuf;
		logic rvalid;
		logic [2:0] beat;
		logic [3:0] wait_cnt;
		logic [9:0] dll_cnt;
		logic pd_req;
	} mrb_ctl_state_t;

	mrb_ctl_state_t r;
	mrb_ctl_state_t next_r;
	logic issue_reg;
	logic can_go;
	logic wr_take;
	logic mapped;

	assign issue_reg = (paddr_i == REG_MODE) || (paddr_i == REG_ACCESS);
	// Reads stay blocked until the DLL has had its lock time
	assign can_go = r.st == C_IDLE && !r.pd_req &&
		(paddr_i != REG_ACCESS || pwdata_i[ACC_WR_BIT] || r.dll_cnt == 10'h000);
	assign pready_o = !(psel_i && pwrite_i && issue_reg) || can_go;
	assign wr_take = psel_i && penable_i && pwrite_i && pready_o;
	assign mapped = paddr_i[1:0] == 2'h0 && paddr_i <= REG_POWER;
	assign pslverr_o = psel_i && penable_i && !mapped;

	always_comb
	begin
		prdata_o = 32'h0000_0000;
		if (paddr_i == REG_MODE)
			prdata_o = {14'h0000, r.mode};
		else if (paddr_i == REG_ACCESS)
			prdata_o = {14'h0000, r.addr};
		else if (paddr_i == REG_WDATA_LO)
			prdata_o = r.wbuf[3:0];
		else if (paddr_i == REG_WDATA_HI)
			prdata_o = r.wbuf[7:4];
		else if (paddr_i == REG_RDATA_LO)
			prdata_o = r.rbuf[3:0];
		else if (paddr_i == REG_RDATA_HI)
			prdata_o = r.rbuf[7:4];
		else if (paddr_i == REG_STATUS)
			prdata_o = {28'h000_0000, r.st == C_PD, r.rvalid, r.dll_cnt != 10'h000,
				r.st != C_IDLE};
		else if (paddr_i == REG_POWER)
			prdata_o = {31'h0000_0000, r.pd_req};
	end

	always_comb
	begin
		next_r = r;
		next_r.cmd = MRB_NOP;
		next_r.dq_oe = 1'b0;
		if (r.dll_cnt != 10'h000 && r.cke)
		begin
			next_r.dll_cnt = r.dll_cnt - 10'h001;
		end
		if (wr_take && paddr_i == REG_WDATA_LO)
			next_r.wbuf[3:0] = pwdata_i;
		else if (wr_take && paddr_i == REG_WDATA_HI)
			next_r.wbuf[7:4] = pwdata_i;
		else if (wr_take && paddr_i == REG_POWER)
			next_r.pd_req = pwdata_i[PWR_DOWN_BIT];
		case (r.st)
			C_IDLE:
			begin
				if (wr_take && paddr_i == REG_MODE)
				begin
					next_r.cmd = MRB_MRS;
					next_r.ba = BASE_BANK;
					next_r.addr = pwdata_i[MR_W-1:0] & ~MR_RESERVED;
					// Recovery field always carries WR_CYC, the rounded-up cycle count raised to the five-cycle minimum
					next_r.addr[WR_LO+2:WR_LO] = wr_code(WR_CYC);
					next_r.mode = next_r.addr;
					if (pwdata_i[DLL_RST_BIT])
					begin
						next_r.dll_cnt = DLL_LOCK_CYC;
					end
					next_r.wait_cnt = MOD_CYC;
					next_r.st = C_MOD;
				end
				else if (wr_take && paddr_i == REG_ACCESS)
				begin
					next_r.ba = 3'h0;
					next_r.addr = pwdata_i[MR_W-1:0];
					next_r.beat = 3'h0;
					if (pwdata_i[ACC_WR_BIT])
					begin
						next_r.cmd = MRB_WR;
						next_r.st = C_WBEAT;
					end
					else
					begin
						next_r.cmd = MRB_RD;
						next_r.rvalid = 1'b0;
						next_r.st = C_RWAIT;
					end
				end
				else if (r.pd_req && r.dll_cnt == 10'h000)
				begin
					next_r.cke = 1'b0;
					next_r.st = C_PD;
				end
			end
			C_MOD:
			begin
				next_r.wait_cnt = r.wait_cnt - 4'h1;
				if (r.wait_cnt == 4'h1)
					next_r.st = C_IDLE;
			end
			C_WBEAT:
			begin
				next_r.dq = r.wbuf[r.beat];
				next_r.dq_oe = 1'b1;
				next_r.beat = r.beat + 3'h1;
				if (r.beat == LAST_BEAT)
					next_r.st = C_IDLE;
			end
			C_RWAIT:
			begin
				if (r.beat != 3'h0 || (link.dev_dqs_oe && link.dev_dqs))
				begin
					next_r.rbuf[r.beat] = link.dq;
					next_r.beat = r.beat + 3'h1;
					if (r.beat == LAST_BEAT)
					begin
						next_r.rvalid = 1'b1;
						next_r.st = C_IDLE;
					end
				end
			end
			C_PD:
			begin
				if (!r.pd_req)
				begin
					next_r.cke = 1'b1;
					next_r.wait_cnt = r.mode[PPD_BIT] ? XP_CYC : XPDLL_CYC;
					next_r.st = C_EXIT;
				end
			end
			C_EXIT:
			begin
				next_r.wait_cnt = r.wait_cnt - 4'h1;
				if (r.wait_cnt == 4'h1)
					next_r.st = C_IDLE;
			end
			default:
			begin
				next_r.st = C_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			r <= '0;
			r.cke <= 1'b1;
		end
		else if (clk_en_i)
		begin
			r <= next_r;
		end
	end

	assign link.cke = r.cke;
	assign link.cmd = r.cmd;
	assign link.ba = r.ba;
	assign link.addr = r.addr;
	assign link.ctl_dq = r.dq;
	assign link.ctl_dq_oe = r.dq_oe;
endmodule // mrb_controller

// ==== test/mrb_link_props.sv ====
// Purpose: link checks between controller and device ends
// Assumes: one core clock, asynchronous active-low reset
// Notes: placed beside the link instance, no bind
`timescale 1ns/1ns
module mrb_link_props
	import mrb_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic cke,
	input wire mrb_cmd_t cmd,
	input wire logic [2:0] ba,
	input wire logic [MR_W-1:0] addr,
	input wire logic ctl_dq_oe,
	input wire logic dev_dq_oe,
	input wire logic dev_dqs_oe
);
	logic [9:0] dll_left;
	logic [3:0] mod_left;
	logic [3:0] exit_left;
	logic exit_fast;
	logic cke_d;
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);
	// Loaded one short: the command is seen an edge after it is issued
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			dll_left <= 10'h000;
		else if (cmd == MRB_MRS && ba == BASE_BANK && addr[DLL_RST_BIT])
			dll_left <= DLL_LOCK_CYC - 10'h001;
		else if (cke && dll_left != 10'h000)
			dll_left <= dll_left - 10'h001;
	end
	// Counts left of the mode update and power-down exit waits, one short like dll_left
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			mod_left <= 4'h0;
			exit_left <= 4'h0;
			exit_fast <= 1'b0;
			cke_d <= 1'b1;
		end
		else
		begin
			cke_d <= cke;
			if (cmd == MRB_MRS && ba == BASE_BANK)
				exit_fast <= addr[PPD_BIT];
			if (cmd == MRB_MRS)
				mod_left <= MOD_CYC - 4'h1;
			else if (mod_left != 4'h0)
				mod_left <= mod_left - 4'h1;
			if (cke && !cke_d)
				exit_left <= (exit_fast ? XP_CYC : XPDLL_CYC) - 4'h1;
			else if (exit_left != 4'h0)
				exit_left <= exit_left - 4'h1;
		end
	end
	a_strobe_float: assert property (dev_dq_oe == dev_dqs_oe)
		else $error("strobe and data enables differ");
	a_read_latency: assert property (cmd == MRB_RD |=> !dev_dq_oe[*5] ##[1:10] dev_dq_oe)
		else $error("read data outside latency window");
	a_chop_float: assert property ($rose(dev_dq_oe) |->
		dev_dq_oe[*4] ##1 (dev_dq_oe[*4] or !dev_dq_oe[*4]))
		else $error("read slot not four or eight beats");
	a_write_slots: assert property ($rose(ctl_dq_oe) |-> ctl_dq_oe[*8])
		else $error("write slot shorter than eight beats");
	a_write_follows: assert property (cmd == MRB_WR |=> $rose(ctl_dq_oe))
		else $error("write data not one cycle after command");
	a_mrs_reserved: assert property (cmd == MRB_MRS |-> (addr & MR_RESERVED) == '0)
		else $error("reserved mode bits set");
	a_mrs_recovery: assert property (cmd == MRB_MRS |-> addr[WR_LO+2:WR_LO] == 3'h1)
		else $error("recovery code not rounded up");
	a_mode_delay: assert property (cmd == MRB_MRS |=>
		(cmd != MRB_RD && cmd != MRB_WR)[*8])
		else $error("access too soon after mode set");
	a_dll_wait: assert property (cmd == MRB_RD |-> dll_left == 10'h000)
		else $error("read before lock time");
	a_mrs_idle: assert property (cmd == MRB_MRS |-> !dev_dq_oe && !ctl_dq_oe)
		else $error("mode set during a burst");
	a_mrs_base: assert property (cmd == MRB_MRS |-> ba == BASE_BANK)
		else $error("mode set to another bank");
	a_mode_wait: assert property ((cmd == MRB_RD || cmd == MRB_WR) |-> mod_left == 4'h0)
		else $error("access inside mode update delay");
	a_exit_wait: assert property (cmd != MRB_NOP |-> exit_left == 4'h0)
		else $error("command inside power-down exit delay");
	c_chop_read: cover property ($rose(dev_dq_oe) ##4 !dev_dq_oe);
	c_power_exit: cover property ($rose(cke));
	c_dll_reset: cover property (cmd == MRB_MRS && addr[DLL_RST_BIT]);
	c_write: cover property (cmd == MRB_WR);
endmodule // mrb_link_props

// ==== test/mode_register0_burst_decode_tb.sv ====
// Purpose: drives the controller over APB, judges link and device results
// Assumes: both ends joined by one link instance
// Notes: expected bytes follow the burst order tables
`timescale 1ns/1ns
module mode_register0_burst_decode_tb;
	import mrb_pkg::*;
	logic core_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic clk_en_i = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic dll_locked;
	logic dll_running;
	logic [3:0] rl;
	logic [3:0] wrc;
	logic rec_busy;
	logic burst_busy;
	int miscompares = 0;
	int cmp_count = 0;
	mrb_link_if mrb_link_if_i();
	mrb_device mrb_device_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.link(mrb_link_if_i), .dll_locked_o(dll_locked), .dll_running_o(dll_running),
		.read_latency_o(rl), .write_recovery_o(wrc), .recovery_busy_o(rec_busy),
		.burst_busy_o(burst_busy));
	mrb_controller mrb_controller_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.clk_en_i(clk_en_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .link(mrb_link_if_i));
	mrb_link_props mrb_link_props_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.cke(mrb_link_if_i.cke), .cmd(mrb_link_if_i.cmd), .ba(mrb_link_if_i.ba),
		.addr(mrb_link_if_i.addr), .ctl_dq_oe(mrb_link_if_i.ctl_dq_oe),
		.dev_dq_oe(mrb_link_if_i.dev_dq_oe), .dev_dqs_oe(mrb_link_if_i.dev_dqs_oe));
	initial
	begin
		forever #5 core_clk_i = ~core_clk_i;
	end
	task automatic report_and_stop();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Access writes that request a read may stall for the whole lock time
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		int n;
		logic rdy;
		@(posedge core_clk_i);
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge core_clk_i);
		penable <= 1'b1;
		n = 0;
		// Answer read where settled, at the falling edge before the edge that takes it
		do
		begin
			@(negedge core_clk_i);
			rdy = pready;
			q = prdata;
			err = pslverr;
			@(posedge core_clk_i);
			n++;
		end
		while (rdy !== 1'b1 && n < 3000);
		psel <= 1'b0;
		penable <= 1'b0;
		if (rdy !== 1'b1)
		begin
			miscompares++;
			report_and_stop();
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic r(input logic [7:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0000_0000, q, e);
	endtask
	task automatic wait_stat(input int b, input logic v);
		logic [31:0] q;
		int n;
		n = 0;
		do
		begin
			r(REG_STATUS, q);
			n++;
		end
		while (q[b] !== v && n < 200);
		chk("status bit", 32'(v), 32'(q[b]));
		if (q[b] !== v)
		begin
			report_and_stop();
		end
	endtask
	task automatic wr_burst(input logic [31:0] acc, input logic [31:0] lo, input logic [31:0] hi);
		w(REG_WDATA_LO, lo);
		w(REG_WDATA_HI, hi);
		w(REG_ACCESS, acc);
	endtask
	task automatic rd_burst(input logic [31:0] acc, input logic [31:0] lo,
		input logic [31:0] hi, input logic full);
		logic [31:0] q;
		w(REG_ACCESS, acc);
		wait_stat(2, 1'b1);
		r(REG_RDATA_LO, q);
		chk("read data low", lo, q);
		if (full)
		begin
			r(REG_RDATA_HI, q);
			chk("read data high", hi, q);
		end
	endtask
	task automatic t_reset();
		logic [31:0] q;
		r(REG_MODE, q);
		chk("mode shadow", 32'h0000_0000, q);
		@(negedge core_clk_i);
		chk("read latency", 32'h0000_0005, 32'(rl));
		chk("write recovery", 32'h0000_0005, 32'(wrc));
		chk("dll locked", 32'h0000_0001, 32'(dll_locked));
		$display("test reset done");
	endtask
	task automatic t_seq();
		w(REG_MODE, 32'h0002_61d0);
		wait_stat(1, 1'b1);
		@(negedge core_clk_i);
		chk("dll locked", 32'h0000_0000, 32'(dll_locked));
		chk("read latency", 32'h0000_0009, 32'(rl));
		chk("write recovery", 32'h0000_0005, 32'(wrc));
		wr_burst(32'h0100_000b, 32'ha3a2_a1a0, 32'ha7a6_a5a4);
		repeat (2) @(negedge core_clk_i);
		chk("burst busy", 32'h0000_0001, 32'(burst_busy));
		repeat (BEATS + 1) @(negedge core_clk_i);
		chk("burst busy", 32'h0000_0000, 32'(burst_busy));
		chk("recovery busy", 32'h0000_0001, 32'(rec_busy));
		repeat (WR_CYC - 1) @(negedge core_clk_i);
		chk("recovery busy", 32'h0000_0000, 32'(rec_busy));
		rd_burst(32'h0000_000b, 32'ha2a1_a0a3, 32'ha6a5_a4a7, 1'b1);
		chk("dll locked", 32'h0000_0001, 32'(dll_locked));
		$display("test sequential done");
	endtask
	task automatic t_inter();
		w(REG_MODE, 32'h0000_0024);
		repeat (2) @(negedge core_clk_i);
		chk("read latency", 32'h0000_000e, 32'(rl));
		rd_burst(32'h0000_0008, 32'ha3a2_a1a0, 32'ha7a6_a5a4, 1'b1);
		w(REG_MODE, 32'h0000_0058);
		rd_burst(32'h0000_000d, 32'ha6a7_a4a5, 32'ha2a3_a0a1, 1'b1);
		w(REG_MODE, 32'h0000_0052);
		rd_burst(32'h0000_000e, 32'ha5a4_a7a6, 32'h0000_0000, 1'b0);
		$display("test order and chop done");
	endtask
	task automatic t_otf();
		w(REG_MODE, 32'h0000_0051);
		wr_burst(32'h0100_000e, 32'h5453_5251, 32'heeee_eeee);
		rd_burst(32'h0000_1008, 32'ha3a2_a1a0, 32'h5453_5251, 1'b1);
		$display("test per command done");
	endtask
	task automatic t_power();
		for (int i = 0; i < 2; i++)
		begin
			w(REG_MODE, 32'h0000_0050 | (32'(i) << PPD_BIT));
			w(REG_POWER, 32'h0000_0001);
			wait_stat(3, 1'b1);
			@(negedge core_clk_i);
			chk("dll running", 32'(i), 32'(dll_running));
			w(REG_POWER, 32'h0000_0000);
			wait_stat(3, 1'b0);
		end
		$display("test power down done");
	endtask
	task automatic t_unmapped();
		logic [31:0] q;
		logic e;
		apb(1'b0, 8'h20, 32'h0000_0000, q, e);
		chk("pslverr", 32'h0000_0001, 32'(e));
		chk("read data", 32'h0000_0000, q);
		apb(1'b1, 8'h02, 32'hffff_ffff, q, e);
		chk("pslverr", 32'h0000_0001, 32'(e));
		$display("test unmapped done");
	endtask
	task automatic t_clk_en();
		logic [31:0] q;
		w(REG_WDATA_LO, 32'h1234_5678);
		clk_en_i <= 1'b0;
		w(REG_WDATA_LO, 32'h0bad_0bad);
		clk_en_i <= 1'b1;
		r(REG_WDATA_LO, q);
		chk("frozen write", 32'h1234_5678, q);
		$display("test clock enable done");
	endtask
	initial
	begin
		repeat (8) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		t_reset();
		t_seq();
		t_inter();
		t_otf();
		t_power();
		t_unmapped();
		t_clk_en();
		report_and_stop();
	end
endmodule // mode_register0_burst_decode_tb
